// ==== rtl/amp_regs_cfg.svh ====
`ifndef AMP_REGS_CFG_SVH
`define AMP_REGS_CFG_SVH

// register pointers on the control bus
`define OFS_FLAGS 8'h02
`define OFS_MASK 8'h03
`define OFS_SYS 8'h04
`define OFS_AUD 8'h05

// reset values
`define RST_FLAGS 15'h4000
`define RST_MASK 15'h7fff
`define RST_SYS 16'h6007
`define RST_AUD 16'h04e8

// writable bits of the control words
`define WM_SYS 16'h7ffb
`define WM_AUD 16'h2fff

// fixed read value of reserved mask bit 15
`define MASK_RSVD 1'h1

// system control field positions
`define SYS_SPK_HI 14
`define SYS_SPK_LO 12
`define SYS_EAR_HI 11
`define SYS_EAR_LO 10
`define SYS_SRC_BIT 8
`define SYS_DRV_BIT 9
`define SYS_EAR_MODE 7
`define SYS_PORT_EN 6
`define SYS_SWAP 5
`define SYS_BCK_INV 4
`define SYS_PLL_REF 3
`define SYS_AMP_PD 1
`define SYS_PWR_PD 0

// audio port control field positions
`define AUD_ATTEN 13
`define AUD_CHS_HI 11
`define AUD_CHS_LO 10
`define AUD_FMT_HI 9
`define AUD_FMT_LO 8
`define AUD_WID_HI 7
`define AUD_WID_LO 6
`define AUD_RAT_HI 5
`define AUD_RAT_LO 4
`define AUD_SR_HI 3
`define AUD_SR_LO 0

// cycles until the status synchroniser holds real samples
`define PRIME_DONE 2'h3
// last bit index of a byte on the control bus
`define LAST_BIT 3'h7
// default bus address, arbitrary
`define DEV_ADDR_DEF 7'h34

`endif

// ==== rtl/amp_regs_pkg.sv ====
package amp_regs_pkg;

   typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_MACK}
      bus_phase_t;

   typedef enum logic [1:0] {K_DEV, K_PTR, K_HI, K_LO} byte_kind_t;

   typedef struct packed {
      logic [2:0] speaker_gain_sel;
      logic [1:0] earpiece_gain_sel;
      logic earpiece_mode;
      logic amp_powerdown;
      logic system_powerdown;
   } sys_cfg_t;

   typedef struct packed {
      logic audio_port_enable;
      logic channel_swap;
      logic bitclk_invert;
      logic pll_ref_select;
      logic input_attenuate;
      logic [1:0] channel_select;
      logic [1:0] audio_format_select;
      logic [1:0] sample_width_select;
      logic [1:0] bitclk_ratio_select;
      logic [3:0] sample_rate_select;
   } aud_cfg_t;

   typedef struct packed {
      logic scl_s1, scl_s2, scl_d;
      logic sda_s1, sda_s2, sda_d;
      logic [14:0] st_s1, st_s2, st_d;
      logic [1:0] prime;
      logic [14:0] flags;
      logic [14:0] mask;
      logic [15:0] sys;
      logic [15:0] aud;
      bus_phase_t phase;
      byte_kind_t kind;
      logic [2:0] cnt;
      logic rw, ack_drv, need_load, rd_lo;
      logic [7:0] ptr, sh, wbuf;
      logic [15:0] rbuf;
      logic sda_oe, irq_o, irq_oe;
      logic req, busy, ack_s1, ack_s2;
      aud_cfg_t shadow;
   } core_state_t;

   typedef struct packed {
      logic rst_s1, rst_s2;
      logic req_s1, req_s2, ack;
      aud_cfg_t cfg;
   } link_state_t;

endpackage : amp_regs_pkg

// ==== rtl/amp_interrupt_control_regs.sv ====
// Behaviour
// R1 - fifteen flags set on status change
// R2 - flag register read clears all flags
// R3 - flag 14 set at power-on, undervolt
// R4 - mask bit one suppresses; resets ones
// R5 - mode bit0 picks flags or live status
// R6 - mode bit1 picks open-drain or push-pull
// R7 - speaker gain field, reset code six
// R8 - earpiece gain field, reset zero
// R9 - bit 7 selects earpiece mode
// R10 - bit 6 enables audio port
// R11 - bit 5 swaps left and right
// R12 - bit 4 inverts bit clock
// R13 - bit 3 picks PLL reference
// R14 - bit 1 amplifier powerdown, reset one
// R15 - bit 0 system powerdown, reset one
// R16 - bit 13 attenuates input 6 dB
// R17 - channel select field, reset left
// R18 - audio format field, default standard
// R19 - sample width field, reset 32
// R20 - bit clock ratio field, default 64
// R21 - sample rate field, default 48k
// R22 - live status feeds the flags
// R23 - irq pin low while unmasked source set
`timescale 1ns/1ps
`include "amp_regs_cfg.svh"

module amp_interrupt_control_regs #(
   parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEF
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic BCK_CLK,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic [14:0] STATUS_IN,
   output logic IRQ_N_O,
   output logic IRQ_N_OE,
   output amp_regs_pkg::sys_cfg_t SYS_CFG,
   output amp_regs_pkg::aud_cfg_t AUD_CFG
);
   import amp_regs_pkg::*;

   core_state_t s, n;
   link_state_t l, m;
   logic start, stop, rise, fall, do_load, wr_evt, act;
   logic [7:0] byte_in;
   logic [15:0] wr_word, word;
   logic [14:0] chg, clr, src;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] val,
                                         input logic [15:0] wm);
      merge = (old & ~wm) | (val & wm);
   endfunction : merge

   function automatic sys_cfg_t to_sys(input logic [15:0] w);
      sys_cfg_t c;
      // R7 speaker gain code
      c.speaker_gain_sel = w[`SYS_SPK_HI:`SYS_SPK_LO];
      // R8 earpiece gain code
      c.earpiece_gain_sel = w[`SYS_EAR_HI:`SYS_EAR_LO];
      // R9 output mode
      c.earpiece_mode = w[`SYS_EAR_MODE];
      // R14 amplifier power down
      c.amp_powerdown = w[`SYS_AMP_PD];
      // R15 system power down
      c.system_powerdown = w[`SYS_PWR_PD];
      to_sys = c;
   endfunction : to_sys

   function automatic aud_cfg_t to_aud(input logic [15:0] sw,
                                       input logic [15:0] aw);
      aud_cfg_t c;
      // R10 port enable
      c.audio_port_enable = sw[`SYS_PORT_EN];
      // R11 channel swap
      c.channel_swap = sw[`SYS_SWAP];
      // R12 clock inversion
      c.bitclk_invert = sw[`SYS_BCK_INV];
      // R13 pll reference
      c.pll_ref_select = sw[`SYS_PLL_REF];
      // R16 input attenuation
      c.input_attenuate = aw[`AUD_ATTEN];
      // R17 channel select
      c.channel_select = aw[`AUD_CHS_HI:`AUD_CHS_LO];
      // R18 frame format
      c.audio_format_select = aw[`AUD_FMT_HI:`AUD_FMT_LO];
      // R19 sample width
      c.sample_width_select = aw[`AUD_WID_HI:`AUD_WID_LO];
      // R20 bit clock ratio
      c.bitclk_ratio_select = aw[`AUD_RAT_HI:`AUD_RAT_LO];
      // R21 sample rate
      c.sample_rate_select = aw[`AUD_SR_HI:`AUD_SR_LO];
      to_aud = c;
   endfunction : to_aud

   function automatic logic [15:0] rd_word(input core_state_t c);
      unique case (c.ptr)
         `OFS_FLAGS: rd_word = {1'h0, c.flags};
         `OFS_MASK: rd_word = {`MASK_RSVD, c.mask};
         `OFS_SYS: rd_word = c.sys;
         `OFS_AUD: rd_word = c.aud;
         default: rd_word = 16'h0000;
      endcase
   endfunction : rd_word

   always_comb begin
      n = s;
      clr = 15'h0000;
      wr_evt = 1'b0;
      wr_word = 16'h0000;
      do_load = 1'b0;
      byte_in = {s.sh[6:0], s.sda_s2};
      word = rd_word(s);
      n.scl_s1 = SCL_I;
      n.scl_s2 = s.scl_s1;
      n.scl_d = s.scl_s2;
      n.sda_s1 = SDA_I;
      n.sda_s2 = s.sda_s1;
      n.sda_d = s.sda_s2;
      // R22 live status sync
      n.st_s1 = STATUS_IN;
      n.st_s2 = s.st_s1;
      n.st_d = s.st_s2;
      if (s.prime != `PRIME_DONE) begin
         n.prime = s.prime + 2'h1;
      end
      // R1 change detect
      chg = (s.prime == `PRIME_DONE) ? (s.st_s2 ^ s.st_d) : 15'h0000;
      start = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
      stop = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;
      rise = s.scl_s2 && !s.scl_d;
      fall = !s.scl_s2 && s.scl_d;
      if (start) begin
         n.phase = PH_RX;
         n.kind = K_DEV;
         n.cnt = 3'h0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.phase = PH_IDLE;
         n.sda_oe = 1'b0;
      end else if (rise) begin
         unique case (s.phase)
            PH_RX: begin
               n.sh = byte_in;
               n.cnt = s.cnt + 3'h1;
               if (s.cnt == `LAST_BIT) begin
                  n.phase = PH_ACK;
                  n.ack_drv = 1'b0;
                  unique case (s.kind)
                     K_DEV: begin
                        if (byte_in[7:1] == DEV_ADDR) begin
                           n.rw = byte_in[0];
                           n.kind = K_PTR;
                           n.rd_lo = 1'b0;
                        end else begin
                           n.phase = PH_IDLE;
                        end
                     end
                     K_PTR: begin
                        n.ptr = byte_in;
                        n.kind = K_HI;
                     end
                     K_HI: begin
                        n.wbuf = byte_in;
                        n.kind = K_LO;
                     end
                     K_LO: begin
                        wr_evt = 1'b1;
                        wr_word = {s.wbuf, byte_in};
                        n.ptr = s.ptr + 8'h01;
                        n.kind = K_HI;
                     end
                  endcase
               end
            end
            PH_TX: begin
               n.cnt = s.cnt + 3'h1;
               if (s.cnt == `LAST_BIT) begin
                  n.phase = PH_MACK;
               end
            end
            PH_MACK: begin
               // master nack ends the read
               if (s.sda_s2) begin
                  n.phase = PH_IDLE;
               end else begin
                  n.phase = PH_TX;
                  n.need_load = 1'b1;
               end
            end
            PH_IDLE, PH_ACK: ;
         endcase
      end else if (fall) begin
         unique case (s.phase)
            PH_ACK: begin
               if (!s.ack_drv) begin
                  n.sda_oe = 1'b1;
                  n.ack_drv = 1'b1;
               end else if (s.rw) begin
                  do_load = 1'b1;
               end else begin
                  n.sda_oe = 1'b0;
                  n.phase = PH_RX;
                  n.cnt = 3'h0;
               end
            end
            PH_TX: begin
               if (s.need_load) begin
                  do_load = 1'b1;
               end else begin
                  n.sh = {s.sh[6:0], 1'b0};
                  n.sda_oe = !s.sh[6];
               end
            end
            PH_MACK: n.sda_oe = 1'b0;
            PH_IDLE, PH_RX: ;
         endcase
      end
      // word captured whole so both bytes match
      if (do_load) begin
         if (!s.rd_lo) begin
            n.rbuf = word;
            n.sh = word[15:8];
            n.rd_lo = 1'b1;
            // R2 clear on read
            if (s.ptr == `OFS_FLAGS) begin
               clr = s.flags;
            end
         end else begin
            n.sh = s.rbuf[7:0];
            n.ptr = s.ptr + 8'h01;
            n.rd_lo = 1'b0;
         end
         n.sda_oe = !n.sh[7];
         n.phase = PH_TX;
         n.cnt = 3'h0;
         n.need_load = 1'b0;
      end
      // R1 R3 set beats clear
      n.flags = (s.flags & ~clr) | chg;
      // R4 mask write
      if (wr_evt && s.ptr == `OFS_MASK) begin
         n.mask = wr_word[14:0];
      end
      if (wr_evt && s.ptr == `OFS_SYS) begin
         n.sys = merge(s.sys, wr_word, `WM_SYS);
      end
      if (wr_evt && s.ptr == `OFS_AUD) begin
         n.aud = merge(s.aud, wr_word, `WM_AUD);
      end
      // R5 pin source
      src = s.sys[`SYS_SRC_BIT] ? s.st_s2 : s.flags;
      // R23 masked any
      act = |(src & ~s.mask);
      // R6 driver style
      if (s.sys[`SYS_DRV_BIT]) begin
         n.irq_o = !act;
         n.irq_oe = 1'b1;
      end else begin
         n.irq_o = 1'b0;
         n.irq_oe = act;
      end
      // shadow frozen until the link acknowledges
      n.ack_s1 = l.ack;
      n.ack_s2 = s.ack_s1;
      if (s.busy) begin
         if (s.ack_s2 == s.req) begin
            n.busy = 1'b0;
         end
      end else if (to_aud(s.sys, s.aud) != s.shadow) begin
         n.shadow = to_aud(s.sys, s.aud);
         n.req = !s.req;
         n.busy = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      s <= n;
      if (!RST_N) begin
         s <= '0;
         s.phase <= PH_IDLE;
         s.kind <= K_DEV;
         s.scl_s1 <= 1'b1;
         s.scl_s2 <= 1'b1;
         s.scl_d <= 1'b1;
         s.sda_s1 <= 1'b1;
         s.sda_s2 <= 1'b1;
         s.sda_d <= 1'b1;
         s.flags <= `RST_FLAGS;
         s.mask <= `RST_MASK;
         s.sys <= `RST_SYS;
         s.aud <= `RST_AUD;
         s.irq_o <= 1'b1;
         s.shadow <= to_aud(`RST_SYS, `RST_AUD);
      end
   end

   // link side: bit clock may stop, handshake just waits
   always_comb begin
      m = l;
      m.rst_s1 = RST_N;
      m.rst_s2 = l.rst_s1;
      m.req_s1 = s.req;
      m.req_s2 = l.req_s1;
      // R20 R21 config to link
      if (l.req_s2 != l.ack) begin
         m.cfg = s.shadow;
         m.ack = l.req_s2;
      end
   end

   always_ff @(posedge BCK_CLK) begin
      l <= m;
      if (!l.rst_s2) begin
         l.req_s1 <= 1'b0;
         l.req_s2 <= 1'b0;
         l.ack <= 1'b0;
         l.cfg <= to_aud(`RST_SYS, `RST_AUD);
      end
   end

   assign SDA_O = 1'b0;
   assign SDA_OE = s.sda_oe;
   assign IRQ_N_O = s.irq_o;
   assign IRQ_N_OE = s.irq_oe;
   assign SYS_CFG = to_sys(s.sys);
   assign AUD_CFG = l.cfg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   logic irq_on;
   assign irq_on = s.irq_oe && !s.irq_o;

   a_flag_sets: assert property ( // R1
      (chg != 15'h0000) |=> ((s.flags & $past(chg)) == $past(chg)))
      else $error("changed status did not set its flag");
   a_flag_hold: assert property ( // R2
      (clr == 15'h0000) |=> (($past(s.flags) & ~s.flags) == 15'h0000))
      else $error("flag dropped without a read");
   a_flag_clear: assert property ( // R2
      (clr != 15'h0000 && chg == 15'h0000) |=> (s.flags == 15'h0000))
      else $error("read did not clear the flags");
   a_undervolt_flag: assert property ( // R3
      chg[14] |=> s.flags[14])
      else $error("undervolt change missed flag 14");
   a_mask_silences: assert property ( // R4
      (s.mask == `RST_MASK) [*2] |=> !irq_on)
      else $error("irq asserted with all masks set");
   a_live_source: assert property ( // R5
      (s.sys[`SYS_SRC_BIT] && |(s.st_s2 & ~s.mask)) |=> irq_on)
      else $error("live status did not drive the pin");
   a_open_drain: assert property ( // R6
      !s.sys[`SYS_DRV_BIT] |=> !s.irq_o)
      else $error("open-drain pin driven high");
   a_push_pull: assert property ( // R6
      s.sys[`SYS_DRV_BIT] |=> s.irq_oe)
      else $error("push-pull pin not driven");
   a_irq_follows: assert property ( // R23
      act |=> irq_on ##0 (!$past(act) || irq_on))
      else $error("pin not asserted for active source");
   a_sys_write: assert property ( // R14
      (wr_evt && s.ptr == `OFS_SYS) |=>
         (s.sys == merge($past(s.sys), $past(wr_word), `WM_SYS)))
      else $error("system control write lost");
   a_aud_write: assert property ( // R19
      (wr_evt && s.ptr == `OFS_AUD) |=>
         (s.aud == merge($past(s.aud), $past(wr_word), `WM_AUD)))
      else $error("audio control write lost");
   a_cfg_cross: assert property ( // R20
      @(posedge BCK_CLK) disable iff (!l.rst_s2)
      (l.req_s2 != l.ack) |=> (l.cfg == $past(s.shadow)))
      else $error("link config not taken from shadow");

   c_read_clear: cover property (clr != 15'h0000);
   c_sys_write: cover property (wr_evt && s.ptr == `OFS_SYS);
   c_irq_on: cover property ($rose(irq_on));
   c_link_update: cover property (
      @(posedge BCK_CLK) (l.req_s2 != l.ack));

endmodule : amp_interrupt_control_regs

// ==== dv/ctrl_bus_host.sv ====
`timescale 1ns/1ps
module ctrl_bus_host #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_low
);
   localparam int Q = 8;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // quarter bit; slow enough for the 2-flop pin sync
   task automatic tick();
      repeat (Q) @(posedge clk);
      #1;
   endtask : tick

   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      tick();
      scl = 1'b1;
      tick();
      r = sda_in;
      tick();
      scl = 1'b0;
      tick();
   endtask : bit_io

   // also serves as repeated start
   task automatic start();
      sda_low = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_low = 1'b1;
      tick();
      scl = 1'b0;
      tick();
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_low = 1'b0;
      tick();
   endtask : stop

   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : send

   // last byte gets a nack so the device lets go
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask : recv

   task automatic wr(input logic [7:0] ptr, input logic [15:0] w0,
                     input logic [15:0] w1, input logic two,
                     output logic ok);
      logic a0, a1, a2, a3, a4, a5;
      start();
      send({ADDR, 1'b0}, a0);
      send(ptr, a1);
      send(w0[15:8], a2);
      send(w0[7:0], a3);
      a4 = 1'b1;
      a5 = 1'b1;
      if (two) begin
         send(w1[15:8], a4);
         send(w1[7:0], a5);
      end
      stop();
      ok = a0 & a1 & a2 & a3 & a4 & a5;
   endtask : wr

   task automatic rd(input logic [7:0] ptr, output logic [15:0] v,
                     output logic ok);
      logic a0, a1, a2;
      start();
      send({ADDR, 1'b0}, a0);
      send(ptr, a1);
      start();
      send({ADDR, 1'b1}, a2);
      recv(1'b0, v[15:8]);
      recv(1'b1, v[7:0]);
      stop();
      ok = a0 & a1 & a2;
   endtask : rd
endmodule : ctrl_bus_host

// ==== dv/amp_interrupt_control_regs_tb.sv ====
`timescale 1ns/1ps
module amp_interrupt_control_regs_tb;
   import amp_regs_pkg::*;
   localparam logic [6:0] ADDR = 7'h2a;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic bck_clk = 1'b0;
   logic [14:0] status = 15'h0000;
   logic scl, host_low, sda_wire, sda_o, sda_oe, irq_o, irq_oe, ok;
   logic [15:0] rv;
   sys_cfg_t sys_cfg;
   aud_cfg_t aud_cfg;
   int n_mismatch = 0;
   int n_tests = 0;

   always #2.5 core_clk = ~core_clk;
   always #32 bck_clk = ~bck_clk;
   // pull-up on the shared data line
   assign sda_wire = !(host_low | (sda_oe & !sda_o));

   amp_interrupt_control_regs #(.DEV_ADDR(ADDR)) amp_interrupt_control_regs_i (
      .CORE_CLK(core_clk),
      .RST_N(rst_n),
      .BCK_CLK(bck_clk),
      .SCL_I(scl),
      .SDA_I(sda_wire),
      .SDA_O(sda_o),
      .SDA_OE(sda_oe),
      .STATUS_IN(status),
      .IRQ_N_O(irq_o),
      .IRQ_N_OE(irq_oe),
      .SYS_CFG(sys_cfg),
      .AUD_CFG(aud_cfg)
   );

   ctrl_bus_host #(.ADDR(ADDR)) ctrl_bus_host_i (
      .clk(core_clk),
      .sda_in(sda_wire),
      .scl(scl),
      .sda_low(host_low)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task automatic rchk(input logic [7:0] ptr, input logic [15:0] exp);
      ctrl_bus_host_i.rd(ptr, rv, ok);
      check({31'h0, ok}, 32'h1);
      check({16'h0, rv}, {16'h0, exp});
   endtask : rchk

   task automatic wchk(input logic [7:0] ptr, input logic [15:0] w0,
                       input logic [15:0] w1, input logic two);
      ctrl_bus_host_i.wr(ptr, w0, w1, two, ok);
      check({31'h0, ok}, 32'h1);
   endtask : wchk

   // sync, edge detect and output flop need a few edges
   task automatic irq_chk(input logic oe, input logic o);
      cyc(10);
      check({30'h0, irq_oe, irq_o}, {30'h0, oe, o});
   endtask : irq_chk

   // link copy moves only on the bit clock, so poll it
   task automatic aud_chk(input logic [16:0] exp);
      for (int i = 0; i < 400; i++) begin
         if (aud_cfg === exp) break;
         cyc(1);
      end
      check({15'h0, aud_cfg}, {15'h0, exp});
   endtask : aud_chk

   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (90000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      // link reset still lands: its sync holds it low for two more edges
      repeat (20) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      cyc(4);
      check({24'h0, sys_cfg}, 32'hc3);
      aud_chk(17'h004e8);
      rchk(8'h02, 16'h4000);
      rchk(8'h02, 16'h0000);
      rchk(8'h03, 16'hffff);
      rchk(8'h04, 16'h6007);
      rchk(8'h05, 16'h04e8);
      rchk(8'h07, 16'h0000);
      ctrl_bus_host_i.start();
      ctrl_bus_host_i.send({ADDR + 7'h1, 1'b0}, ok);
      ctrl_bus_host_i.stop();
      check({31'h0, ok}, 32'h0);
      wchk(8'h04, 16'h36f2, 16'hffff, 1'b1);
      rchk(8'h04, 16'h36f6);
      rchk(8'h05, 16'h2fff);
      cyc(4);
      check({24'h0, sys_cfg}, 32'h6e);
      aud_chk(17'h1dfff);
      status = 15'h0001;
      irq_chk(1'b1, 1'b1);
      wchk(8'h03, 16'hfffe, 16'h0000, 1'b0);
      irq_chk(1'b1, 1'b0);
      rchk(8'h02, 16'h0001);
      irq_chk(1'b1, 1'b1);
      status = 15'h4081;
      cyc(10);
      rchk(8'h02, 16'h4080);
      wchk(8'h04, 16'h4908, 16'h0915, 1'b1);
      rchk(8'h04, 16'h490c);
      cyc(4);
      check({24'h0, sys_cfg}, 32'h90);
      aud_chk(17'h02915);
      irq_chk(1'b1, 1'b0);
      status = 15'h4080;
      irq_chk(1'b0, 1'b0);
      tally_and_finish();
   end
endmodule : amp_interrupt_control_regs_tb
